// File: common/irq_pkg.sv
package irq_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NUM_GROUPS    = 4;
  localparam int SRC_PER_GROUP = 4;
  localparam int NUM_SRC       = 16;
  localparam int NUM_PINS      = 3;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic       GIE_RST      = 1'b0;
  localparam logic [15:0] SRC_FLAG_RST = 16'h0000;
  localparam logic [3:0]  GRP_FLAG_RST = 4'h0;
  localparam logic [1:0]  VECTOR_RST   = 2'h0;

  // ****************************************
  // pin event edge modes
  // ****************************************
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // pin0 external falling edge, pin1 low supply, pin2 comparator change
  localparam logic [5:0] PIN_EDGE_MODES = {EDGE_BOTH, EDGE_RISE, EDGE_FALL};

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [3:0] {
    ST_RUN    = 4'h1,
    ST_IDLE   = 4'h2,
    ST_SLEEP  = 4'h4,
    ST_RESUME = 4'h8
  } pwr_state_t;

  typedef struct packed {
    logic [15:0] src_set;
    logic [15:0] src_clr;
    logic [3:0]  grp_set;
    logic [3:0]  grp_clr;
    logic        gie_wr;
    logic        gie_val;
  } sw_cmd_t;

  typedef struct packed {
    logic [15:0] src_en;
    logic [3:0]  grp_en;
  } en_cfg_t;

  typedef struct packed {
    logic boundary;
    logic stack_full;
    logic subroutine_return_op;
    logic return_from_interrupt_op;
  } core_cmd_t;

endpackage : irq_pkg

// File: logic/pin_event_sync.sv
`timescale 1ns/100ps
module pin_event_sync
  import irq_pkg::*;
#(
  parameter logic [1:0] MODE = EDGE_RISE
) (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic pin,
  output logic      evt
);

  // ****************************************
  // two-stage synchroniser and edge detect
  // ****************************************
  logic       meta;
  logic       sync;
  logic       prev;
  logic [1:0] fill;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
      fill <= 2'h0;
      evt  <= 1'b0;
    end else begin
      meta <= pin;
      sync <= meta;
      prev <= sync;
      // no edge until all three stages (meta, sync, prev) hold real pin levels
      fill <= (fill == 2'h3) ? fill : fill + 2'h1;
      evt  <= (fill == 2'h3) & ((MODE[0] & sync & ~prev) | (MODE[1] & ~sync & prev));
    end
  end

endmodule : pin_event_sync

// File: logic/irq_wake_ctrl.sv
`timescale 1ns/100ps
// Operation
// (R01) rising request flag wakes sleep or idle
// (R02) wake ignores all enable bits
// (R03) flags writable; already-set flag cannot wake
// (R04) pin, supply, comparator flags set while stopped
// (R05) enables block service only; flags stay set
// (R06) service clears group flag only
// (R07) entry pushes program counter only
// (R08) interrupt return pops and sets global enable
// (R09) plain return pops, global enable unchanged
// (R10) taking interrupt clears global enable
// (R11) vector needs flag, all enables, stack room
// (R12) wake resumes; vector only if enabled
module irq_wake_ctrl
  import irq_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  input  wire logic [NUM_SRC-1:0]    src_evt,
  input  wire logic [NUM_PINS-1:0]   wake_pin,
  input  wire sw_cmd_t               sw,
  input  wire en_cfg_t               en,
  input  wire core_cmd_t             core,
  input  wire logic                  halt_req,
  input  wire logic                  halt_idle,
  output logic [NUM_SRC-1:0]         src_flags,
  output logic [NUM_GROUPS-1:0]      group_request_flags,
  output logic                       global_int_enable,
  output logic                       int_take,
  output logic [1:0]                 int_vector,
  output logic                       push_pc,
  output logic                       pop_pc,
  output logic                       wake,
  output logic                       sys_clk_run,
  output logic                       cpu_run,
  output pwr_state_t                 power_state
);

  // ****************************************
  // pin event capture
  // ****************************************
  logic [NUM_PINS-1:0] pin_evt;

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PINS; gp++) begin : g_pin
      pin_event_sync #(
        .MODE (PIN_EDGE_MODES[2*gp +: 2])
      ) u_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .pin      (wake_pin[gp]),
        .evt      (pin_evt[gp])
      );
    end
  endgenerate

  // ****************************************
  // source request flags
  // ****************************************
  logic [NUM_SRC-1:0] src_set;

  always_comb begin
    src_set = src_evt | sw.src_set;
    src_set[NUM_PINS-1:0] = src_set[NUM_PINS-1:0] | pin_evt; // [R04]
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      src_flags <= SRC_FLAG_RST;
    end else begin
      src_flags <= (src_flags & ~sw.src_clr) | src_set; // [R03] [R05]
    end
  end

  // ****************************************
  // service decision
  // ****************************************
  logic [NUM_GROUPS-1:0] member_any;
  logic [NUM_GROUPS-1:0] member_ok;
  logic [NUM_GROUPS-1:0] member_prev;
  logic [NUM_GROUPS-1:0] eligible;
  logic                  take;
  logic [1:0]            take_vec;
  logic [NUM_GROUPS-1:0] take_clr;

  genvar gg;
  generate
    for (gg = 0; gg < NUM_GROUPS; gg++) begin : g_grp
      assign member_any[gg] = |src_flags[gg*SRC_PER_GROUP +: SRC_PER_GROUP];
      assign member_ok[gg]  = |(src_flags[gg*SRC_PER_GROUP +: SRC_PER_GROUP]
                               & en.src_en[gg*SRC_PER_GROUP +: SRC_PER_GROUP]);
      assign eligible[gg]   = group_request_flags[gg] & en.grp_en[gg] & member_ok[gg]
                              & global_int_enable & ~core.stack_full; // [R11]
    end
  endgenerate

  always_comb begin
    take     = 1'b0;
    take_vec = VECTOR_RST;
    take_clr = '0;
    if (power_state == ST_RUN && core.boundary && !int_take) begin // [R12]
      for (int i = NUM_GROUPS - 1; i >= 0; i--) begin
        if (eligible[i]) begin
          take     = 1'b1;
          take_vec = 2'(i);
        end
      end
    end
    if (take) begin
      take_clr[take_vec] = 1'b1;
    end
  end

  // ****************************************
  // group request flags
  // ****************************************
  logic [NUM_GROUPS-1:0] grp_set;

  assign grp_set = (member_any & ~member_prev) | sw.grp_set;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      member_prev         <= GRP_FLAG_RST;
      group_request_flags <= GRP_FLAG_RST;
    end else begin
      member_prev         <= member_any;
      group_request_flags <= (group_request_flags & ~(sw.grp_clr | take_clr))
                             | grp_set; // [R06]
    end
  end

  // ****************************************
  // global enable and stack strobes
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      global_int_enable <= GIE_RST;
    end else if (take) begin
      global_int_enable <= 1'b0; // [R10]
    end else if (core.return_from_interrupt_op) begin
      global_int_enable <= 1'b1; // [R08]
    end else if (sw.gie_wr) begin
      global_int_enable <= sw.gie_val;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      int_take   <= 1'b0;
      int_vector <= VECTOR_RST;
      push_pc    <= 1'b0;
      pop_pc     <= 1'b0;
    end else begin
      int_take   <= take;
      int_vector <= take ? take_vec : int_vector;
      push_pc    <= take; // [R07]
      pop_pc     <= core.return_from_interrupt_op | core.subroutine_return_op; // [R08] [R09]
    end
  end

  // ****************************************
  // power-down and wake-up
  // ****************************************
  logic [NUM_SRC+NUM_GROUPS-1:0] all_flags;
  logic [NUM_SRC+NUM_GROUPS-1:0] flags_prev;
  logic                          rise_any;
  pwr_state_t                    next_state;

  assign all_flags = {group_request_flags, src_flags};
  assign rise_any  = |(all_flags & ~flags_prev); // [R02] [R03]

  always_comb begin
    next_state = power_state;
    unique case (power_state)
      ST_RUN: begin
        if (halt_req) begin
          next_state = halt_idle ? ST_IDLE : ST_SLEEP;
        end
      end
      ST_IDLE, ST_SLEEP: begin
        if (rise_any) begin
          next_state = ST_RESUME; // [R01]
        end
      end
      ST_RESUME: begin
        next_state = ST_RUN; // [R12]
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      flags_prev  <= '0;
      power_state <= ST_RUN;
      wake        <= 1'b0;
      sys_clk_run <= 1'b1;
      cpu_run     <= 1'b1;
    end else begin
      flags_prev  <= all_flags;
      power_state <= next_state;
      wake        <= (next_state == ST_RESUME);
      sys_clk_run <= (next_state != ST_SLEEP);
      cpu_run     <= (next_state == ST_RUN);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  chk_wake_on_rise: assert property ( // [R01]
    (power_state inside {ST_IDLE, ST_SLEEP}) && rise_any
      |=> power_state == ST_RESUME && wake ##1 power_state == ST_RUN && cpu_run)
    else $error("no wake on rising flag");

  chk_wake_no_enable: assert property ( // [R02]
    (power_state inside {ST_IDLE, ST_SLEEP}) && (src_flags & ~$past(src_flags)) != '0
      && en == '0 && !global_int_enable |=> power_state == ST_RESUME)
    else $error("wake gated by enable");

  chk_no_spurious_wake: assert property ( // [R03]
    power_state == ST_SLEEP && !rise_any |=> power_state == ST_SLEEP && !sys_clk_run)
    else $error("wake without rising flag");

  chk_pin_sets_flag: assert property ( // [R04]
    pin_evt != '0 |=> (src_flags[NUM_PINS-1:0] & $past(pin_evt)) == $past(pin_evt))
    else $error("pin event did not set flag");

  chk_flag_holds: assert property ( // [R05]
    1 |=> (($past(src_flags) & ~$past(sw.src_clr)) & ~src_flags) == '0)
    else $error("source flag dropped without clear");

  chk_take_clears_group: assert property ( // [R06]
    take && !grp_set[take_vec] && src_set == '0 && sw.src_clr == '0
      |=> !group_request_flags[int_vector] && src_flags == $past(src_flags))
    else $error("service clear wrong");

  chk_push_on_entry: assert property ( // [R07]
    int_take |-> push_pc && !global_int_enable)
    else $error("entry without push");

  chk_return_from_interrupt_op_sets_gie: assert property ( // [R08]
    core.return_from_interrupt_op && !take |=> global_int_enable && pop_pc)
    else $error("return from interrupt left enable low");

  chk_ret_keeps_gie: assert property ( // [R09]
    core.subroutine_return_op && !core.return_from_interrupt_op && !take && !sw.gie_wr
      |=> global_int_enable == $past(global_int_enable) && pop_pc)
    else $error("plain return changed enable");

  chk_take_clears_gie: assert property ( // [R10]
    take |=> !global_int_enable ##1 (!global_int_enable || $past(core.return_from_interrupt_op)
      || $past(sw.gie_wr)))
    else $error("enable not cleared on entry");

  chk_take_allowed: assert property ( // [R11]
    take |-> group_request_flags[take_vec] && en.grp_en[take_vec] && global_int_enable
      && !core.stack_full && member_ok[take_vec])
    else $error("vector taken while blocked");

  chk_resume_run: assert property ( // [R12]
    power_state == ST_RESUME |-> !take ##1 power_state == ST_RUN)
    else $error("resume did not return to run");

endmodule : irq_wake_ctrl

// File: tb/core_model.sv
`timescale 1ns/100ps
// ****
// core stack and return model
// ****
module core_model
  import irq_pkg::*;
#(
  parameter int STACK_DEPTH = 1
) (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic push_pc,
  input  wire logic pop_pc,
  input  wire logic do_ret,
  input  wire logic do_return_from_interrupt_op,
  input  wire logic hold_off,
  output core_cmd_t core
);
  int depth;
  always @(posedge core_clk) begin
    if (!rstn) depth <= 0;
    else depth <= depth + int'(push_pc) - int'(pop_pc);
  end
  always_comb begin
    core.boundary                 = ~hold_off;
    core.stack_full               = (depth >= STACK_DEPTH);
    core.subroutine_return_op     = do_ret;
    core.return_from_interrupt_op = do_return_from_interrupt_op;
  end
endmodule : core_model

// File: tb/interrupt_wakeup_and_return_control_tb_top.sv
`timescale 1ns/100ps
module interrupt_wakeup_and_return_control_tb_top;
  import irq_pkg::*;
  // ****
  // signals
  // ****
  logic                  core_clk = 1'b0;
  logic                  rstn = 1'b0;
  logic [NUM_SRC-1:0]    src_evt = '0;
  logic [NUM_PINS-1:0]   wake_pin = 3'h1;
  sw_cmd_t               sw = '0;
  en_cfg_t               en = '0;
  core_cmd_t             core;
  logic                  halt_req = 1'b0;
  logic                  halt_idle = 1'b0;
  logic                  do_ret = 1'b0;
  logic                  do_return_from_interrupt_op = 1'b0;
  logic [NUM_SRC-1:0]    src_flags;
  logic [NUM_GROUPS-1:0] group_request_flags;
  logic [1:0]            int_vector;
  logic                  global_int_enable, int_take, push_pc, pop_pc;
  logic                  wake, sys_clk_run, cpu_run, seen;
  pwr_state_t            power_state;
  int                    err_total = 0;
  int                    n_checks = 0;
  typedef struct packed {logic [3:0] idx; logic [15:0] fl; logic [3:0] gf;} row_t;
  localparam row_t ROWS [4] = '{'{4'h3, 16'h0008, 4'h1}, '{4'h5, 16'h0020, 4'h2},
                                '{4'ha, 16'h0400, 4'h4}, '{4'hf, 16'h8000, 4'h8}};
  localparam sw_cmd_t CLR_ALL = '{src_clr: 16'hffff, grp_clr: 4'hf, default: '0};
  localparam sw_cmd_t GIE_ON = '{gie_wr: 1'b1, gie_val: 1'b1, default: '0};

  always #10 core_clk = ~core_clk;

  irq_wake_ctrl i_irq_wake_ctrl (.core_clk, .rstn, .src_evt, .wake_pin, .sw, .en, .core,
    .halt_req, .halt_idle, .src_flags, .group_request_flags, .global_int_enable,
    .int_take, .int_vector, .push_pc, .pop_pc, .wake, .sys_clk_run, .cpu_run,
    .power_state);
  core_model #(.STACK_DEPTH(1)) i_core_model (.core_clk, .rstn, .push_pc, .pop_pc,
    .do_ret, .do_return_from_interrupt_op, .hold_off(1'b0), .core);

  // ****
  // helpers
  // ****
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : check

  task automatic pulse_sw(input sw_cmd_t c);
    sw = c;
    @(negedge core_clk);
    sw = '0;
    @(negedge core_clk);
  endtask : pulse_sw

  task automatic evt(input int i);
    src_evt[i] = 1'b1;
    @(negedge core_clk);
    src_evt = '0;
  endtask : evt

  task automatic wait_sig(input int sel, input string m);
    logic s;
    for (int n = 0; n < 40; n++) begin
      s = (sel == 0) ? int_take : (sel == 1) ? wake : pop_pc;
      if (s === 1'b1) break;
      @(negedge core_clk);
    end
    check(s, 1'b1, m);
  endtask : wait_sig

  task automatic watch(input int sel, input int cyc);
    seen = 1'b0;
    repeat (cyc) begin
      @(negedge core_clk);
      seen = seen | ((sel == 0) ? int_take : wake);
    end
  endtask : watch

  task automatic halt(input logic idle);
    halt_idle = idle;
    halt_req = 1'b1;
    @(negedge core_clk);
    halt_req = 1'b0;
  endtask : halt

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (3000) @(posedge core_clk);
    err_total++;
    $display("MISMATCH t=%0t watchdog", $time);
    complete_run();
  end

  // ****
  // main sequence
  // ****
  initial begin
    repeat (2) @(negedge core_clk);
    rstn = 1'b1;
    @(negedge core_clk);
    check(src_flags, SRC_FLAG_RST, "rst flags");
    check({global_int_enable, int_vector, power_state}, {GIE_RST, VECTOR_RST, ST_RUN}, "rst");
    for (int r = 0; r < 4; r++) begin
      evt(ROWS[r].idx);
      @(negedge core_clk);
      check(src_flags, ROWS[r].fl, "src flag");
      check(group_request_flags, ROWS[r].gf, "group flag");
      pulse_sw(CLR_ALL);
    end
    $display("flag rows done");
    en = '{src_en: 16'h0020, grp_en: 4'h2};
    pulse_sw(GIE_ON);
    evt(5);
    wait_sig(0, "no entry");
    check({int_vector, push_pc}, {2'h1, 1'b1}, "entry");
    check(global_int_enable, 1'b0, "gie after entry");
    check(group_request_flags, 4'h0, "group cleared");
    check(src_flags, 16'h0020, "source kept");
    pulse_sw('{src_clr: 16'h0020, default: '0});
    evt(5);
    pulse_sw(GIE_ON);
    watch(0, 10);
    check(seen, 1'b0, "taken with stack full");
    check(src_flags, 16'h0020, "pending kept");
    pulse_sw('{gie_wr: 1'b1, default: '0});
    check(global_int_enable, 1'b0, "gie before return_from_interrupt_op");
    do_return_from_interrupt_op = 1'b1;
    @(negedge core_clk);
    do_return_from_interrupt_op = 1'b0;
    wait_sig(2, "no pop");
    check(global_int_enable, 1'b1, "gie after return_from_interrupt_op");
    wait_sig(0, "pending not taken");
    do_ret = 1'b1;
    @(negedge core_clk);
    do_ret = 1'b0;
    wait_sig(2, "no pop");
    check(global_int_enable, 1'b0, "gie after ret");
    $display("service done");
    pulse_sw(CLR_ALL);
    en = '0;
    pulse_sw('{src_set: 16'h0080, default: '0});
    halt(1'b0);
    check({power_state, sys_clk_run, cpu_run}, {ST_SLEEP, 2'b00}, "sleep");
    pulse_sw('{src_set: 16'h0080, default: '0});
    watch(1, 8);
    check(seen, 1'b0, "set flag woke");
    evt(9);
    wait_sig(1, "no wake");
    check({power_state, sys_clk_run}, {ST_RESUME, 1'b1}, "resume");
    @(negedge core_clk);
    check({power_state, cpu_run}, {ST_RUN, 1'b1}, "run");
    halt(1'b1);
    check({power_state, sys_clk_run, cpu_run}, {ST_IDLE, 2'b10}, "idle");
    wake_pin[0] = 1'b0;
    wait_sig(1, "no pin wake");
    check(src_flags[0], 1'b1, "pin flag");
    @(negedge core_clk);
    pulse_sw(CLR_ALL);
    wake_pin = 3'h7;
    repeat (5) @(negedge core_clk);
    check(src_flags[2:0], 3'h6, "pin rise modes");
    pulse_sw(CLR_ALL);
    wake_pin[2] = 1'b0;
    repeat (5) @(negedge core_clk);
    check(src_flags[2:0], 3'h4, "pin fall modes");
    $display("power done");
    rstn = 1'b0;
    repeat (2) @(negedge core_clk);
    rstn = 1'b1;
    repeat (5) @(negedge core_clk);
    check(src_flags, SRC_FLAG_RST, "flags after mid reset");
    check({global_int_enable, group_request_flags, power_state},
          {GIE_RST, GRP_FLAG_RST, ST_RUN}, "state after mid reset");
    $display("reset done");
    complete_run();
  end
endmodule : interrupt_wakeup_and_return_control_tb_top
